/* File: gpio_datapath_strap_regs.sv */
// io config, video/audio path control and strap status register bank
`timescale 1ns/100ps
`include "gpio_datapath_params.svh"
module gpio_datapath_strap_regs
    import gpio_datapath_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    input  wire logic        clkEn,
    // register port from the serial control bus
    input  wire logic [7:0]  regAddr,
    input  wire logic        regWrite,
    input  wire logic [7:0]  regWrData,
    input  wire logic        regRead,
    output logic [7:0]       regRdData,
    output logic             regRdValid,
    // general io seven pin
    input  wire logic        ioSevenPinIn,
    output logic             ioSevenPinOut,
    output logic             ioSevenPinOeN,
    output logic             ioSevenFuncIn,
    output logic             ioSevenReadValue,
    // general io eight pin
    input  wire logic        ioEightPinIn,
    output logic             ioEightPinOut,
    output logic             ioEightPinOeN,
    output logic             ioEightFuncIn,
    output logic             ioEightReadValue,
    // strap decode levels
    input  wire logic [2:0]  strapZeroLevel,
    input  wire logic [2:0]  strapOneLevel,
    // pixel path
    input  wire logic        deIn,
    input  wire logic [23:0] pixelIn,
    output logic             pixelValid,
    output logic [23:0]      pixelOut,
    // audio path
    input  wire logic        repeaterMode,
    input  wire logic        inbandAuxDetect,
    input  wire logic        audioFromVideo,
    input  wire logic        audioFromPins,
    input  wire logic        auxAudioInputPin,
    output logic             audioData,
    output logic             auxAudioData,
    output logic             auxAudioEnable,
    output logic             audioInFrame,
    output logic             packetAudioBlock,
    // path status seen by the video core
    output logic             cipherDisable,
    output logic             videoEighteenBit,
    output logic             deActiveLow
);

    // ------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------
    // writable registers, read port next values
    logic [7:0]  ioCfg, next_ioCfg;
    logic [7:0]  pathCtrl, next_pathCtrl;
    logic [7:0]  next_regRdData;
    logic        next_regRdValid;
    logic [7:0]  strapStatus;

    // tracker results
    logic        strapZeroDone;
    logic        strapOneDone;
    logic [2:0]  strapZeroDecode;
    logic [2:0]  strapOneDecode;

    // field taps and pixel shaping
    logic        passRgb;
    logic        audioRegen;
    logic        auxOverride;
    logic        auxEnableBit;
    logic        deQualified;
    logic        forwardPixel;
    logic [23:0] depthPixel;
    logic        auxEnableSel;

    // next values of path outputs
    logic        next_pixelValid;
    logic [23:0] next_pixelOut;
    logic        next_audioData;
    logic        next_auxAudioData;

    // ------------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------------

    // masks keep reserved bits at zero;
    // status or stray offsets match nothing
    // only writable bits of mapped rw registers change
    always_comb begin
        next_ioCfg    = ioCfg;
        next_pathCtrl = pathCtrl;
        if (regWrite) begin
            if (regAddr == `OFF_IO_CFG) begin
                next_ioCfg = regWrData & `WMASK_IO_CFG;
            end else if (regAddr == `OFF_PATH_CTRL) begin
                next_pathCtrl = regWrData & `WMASK_PATH_CTRL;
            end
        end
    end

    // configuration registers, frozen while the clock enable is low
    // reset returns both to zero
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            ioCfg    <= `RST_IO_CFG;
            pathCtrl <= `RST_PATH_CTRL;
        end else if (clkEn) begin
            ioCfg    <= next_ioCfg;
            pathCtrl <= next_pathCtrl;
        end
    end

    // ------------------------------------------------------------------
    // strap status
    // ------------------------------------------------------------------

    // one settle time for both trackers;
    // a moving strap never relatches
    // strap one tracking
    strap_level_tracker #(
        .SETTLE (`STRAP_SETTLE_CYC)
    ) u_strap_one (
        .ref_clk (ref_clk),
        .reset_n (reset_n),
        .clkEn   (clkEn),
        .levelIn (strapOneLevel),
        .done    (strapOneDone),
        .decode  (strapOneDecode)
    );

    // same tracker for strap zero
    // strap zero tracking
    strap_level_tracker #(
        .SETTLE (`STRAP_SETTLE_CYC)
    ) u_strap_zero (
        .ref_clk (ref_clk),
        .reset_n (reset_n),
        .clkEn   (clkEn),
        .levelIn (strapZeroLevel),
        .done    (strapZeroDone),
        .decode  (strapZeroDecode)
    );

    // decode holds the old level while settling
    // status word assembled from the trackers, never written
    always_comb begin
        strapStatus = 8'h00;
        strapStatus[`STRAP1_DONE_BIT] = strapOneDone;
        strapStatus[`STRAP1_DEC_LO +: 3] = strapOneDecode;
        strapStatus[`STRAP0_DONE_BIT] = strapZeroDone;
        strapStatus[`STRAP0_DEC_LO +: 3] = strapZeroDecode;
    end

    // ------------------------------------------------------------------
    // register reads
    // ------------------------------------------------------------------

    // registered read: decode stays off the bus
    // path; a read while clkEn is low is lost
    // unmapped addresses and reserved bits read zero
    always_comb begin
        next_regRdValid = regRead;
        next_regRdData  = regRdData;
        if (regRead) begin
            if (regAddr == `OFF_IO_CFG) begin
                next_regRdData = ioCfg;
            end else if (regAddr == `OFF_PATH_CTRL) begin
                next_regRdData = pathCtrl;
            end else if (regAddr == `OFF_STRAP_STAT) begin
                next_regRdData = strapStatus;
            end else begin
                next_regRdData = 8'h00;
            end
        end
    end

    // read data holds until the next read; a same-cycle write shows later
    // valid pulses once per accepted read
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            regRdData  <= 8'h00;
            regRdValid <= 1'b0;
        end else if (clkEn) begin
            regRdData  <= next_regRdData;
            regRdValid <= next_regRdValid;
        end
    end

    // ------------------------------------------------------------------
    // general io pins
    // ------------------------------------------------------------------

    // pad drivers sit outside this block
    // io seven from bits 3 and 1:0
    io_pin_ctrl u_io_seven (
        .ref_clk   (ref_clk),
        .reset_n   (reset_n),
        .clkEn     (clkEn),
        .mode      (ioCfg[`IO7_MODE_LO +: 2]),
        .outValue  (ioCfg[`IO7_VAL_BIT]),
        .pinIn     (ioSevenPinIn),
        .pinOut    (ioSevenPinOut),
        .pinOeN    (ioSevenPinOeN),
        .funcIn    (ioSevenFuncIn),
        .readValue (ioSevenReadValue)
    );

    // same pin logic for io eight
    // io eight from bits 7 and 5:4
    io_pin_ctrl u_io_eight (
        .ref_clk   (ref_clk),
        .reset_n   (reset_n),
        .clkEn     (clkEn),
        .mode      (ioCfg[`IO8_MODE_LO +: 2]),
        .outValue  (ioCfg[`IO8_VAL_BIT]),
        .pinIn     (ioEightPinIn),
        .pinOut    (ioEightPinOut),
        .pinOeN    (ioEightPinOeN),
        .funcIn    (ioEightFuncIn),
        .readValue (ioEightReadValue)
    );

    // ------------------------------------------------------------------
    // path control decode
    // ------------------------------------------------------------------

    // plain wires: a write acts from the next
    // edge, the whole byte at once
    // plain field taps of the path control register
    assign passRgb      = pathCtrl[`PASS_RGB_BIT];
    assign audioRegen   = pathCtrl[`AUD_REGEN_BIT];
    assign auxOverride  = pathCtrl[`AUX_OVR_BIT];
    assign auxEnableBit = pathCtrl[`AUX_EN_BIT];

    // status bits follow the register
    // polarity of data enable
    assign deActiveLow = pathCtrl[`DE_POL_BIT];

    // depth flag goes to the video core
    // colour depth select
    assign videoEighteenBit = pathCtrl[`VID18_BIT];

    assign audioInFrame = pathCtrl[`AUD_FRAME_BIT];

    // cipher only flagged here; packet audio also gated below
    // pass-through stops cipher and packet audio
    assign cipherDisable    = passRgb;
    assign packetAudioBlock = passRgb;

    // non-repeater ignores in-band detection;
    // override set lets software decide
    // second audio channel enable source
    always_comb begin
        if (repeaterMode && !auxOverride) begin
            auxEnableSel = inbandAuxDetect;
        end else begin
            auxEnableSel = auxEnableBit;
        end
    end
    assign auxAudioEnable = auxEnableSel;

    // ------------------------------------------------------------------
    // pixel path
    // ------------------------------------------------------------------

    // the xor serves both enable polarities;
    // 18-bit keeps six upper bits per lane
    // qualify data enable and shape colour depth
    always_comb begin
        deQualified  = deIn ^ deActiveLow;
        forwardPixel = passRgb || deQualified;
        depthPixel   = pixelIn;
        // 18-bit drops two low bits per colour
        if (videoEighteenBit) begin
            depthPixel[1:0]   = 2'h0;
            depthPixel[9:8]   = 2'h0;
            depthPixel[17:16] = 2'h0;
        end
        next_pixelValid = forwardPixel;
        // blanked pixels go out as zero so idle data is not leaked
        next_pixelOut   = forwardPixel ? depthPixel : 24'h000000;
    end

    // one stage keeps pixel and audio aligned
    // one register stage on the pixel path
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            pixelValid <= 1'b0;
            pixelOut   <= 24'h000000;
        end else if (clkEn) begin
            pixelValid <= next_pixelValid;
            pixelOut   <= next_pixelOut;
        end
    end

    // ------------------------------------------------------------------
    // audio path
    // ------------------------------------------------------------------

    // pass-through gating beats source choice;
    // gate before the flop avoids glitches
    // select and gate the serial audio lines
    always_comb begin
        if (repeaterMode && audioRegen) begin
            next_audioData = audioFromPins;
        end else begin
            next_audioData = audioFromVideo;
        end
        // packet audio held low in pass-through
        if (passRgb) begin
            next_audioData = 1'b0;
        end
        // aux channel from its pin only when enabled
        next_auxAudioData = (auxEnableSel && !passRgb) ?
                            auxAudioInputPin : 1'b0;
    end

    // audio lines are registered to line up with the pixel stage
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            audioData    <= 1'b0;
            auxAudioData <= 1'b0;
        end else if (clkEn) begin
            audioData    <= next_audioData;
            auxAudioData <= next_auxAudioData;
        end
    end

endmodule : gpio_datapath_strap_regs

/* File: gpio_datapath_params.svh */
// offsets, field positions, reset values and timing of the control bank
//
// How it works
// - each two-bit io mode picks functional in, hi-z, driven out, or read in
// - output value bit drives its pin only in driven-out mode, default low
// - pass-through bit forwards pixels whatever the data-enable level
// - pass-through also disables content cipher and blocks packet audio
// - polarity bit zero means data-enable high active, one means low active
// - repeater audio source: video pins when zero, audio pins when one
// - override bit set takes second audio channel enable from bit zero
// - colour depth bit: zero is 24-bit video, one is 18-bit video
// - transport bit: zero data-island audio, one audio inside link frame
// - bit zero enables second audio channel from the aux audio pin
// - repeater may replace second channel enable with in-band detection
// - strap one done bit reads one once its level is stable and latched
// - bits 6:4 return the decoded level of strap one
// - strap zero done bit reads one once its level is stable and latched
// - bits 2:0 return the decoded level of strap zero
`ifndef GPIO_DATAPATH_PARAMS_SVH
`define GPIO_DATAPATH_PARAMS_SVH

// ----------------------------------------------------------------------
// register offsets and reset values
// ----------------------------------------------------------------------
`define OFF_IO_CFG       8'h11
`define OFF_PATH_CTRL    8'h12
`define OFF_STRAP_STAT   8'h13
`define RST_IO_CFG       8'h00
`define RST_PATH_CTRL    8'h00
`define RST_STRAP_STAT   8'h88
`define WMASK_IO_CFG     8'hbb
`define WMASK_PATH_CTRL  8'h7f

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define IO8_VAL_BIT      7
`define IO8_MODE_LO      4
`define IO7_VAL_BIT      3
`define IO7_MODE_LO      0
`define PASS_RGB_BIT     6
`define DE_POL_BIT       5
`define AUD_REGEN_BIT    4
`define AUX_OVR_BIT      3
`define VID18_BIT        2
`define AUD_FRAME_BIT    1
`define AUX_EN_BIT       0
`define STRAP1_DONE_BIT  7
`define STRAP1_DEC_LO    4
`define STRAP0_DONE_BIT  3
`define STRAP0_DEC_LO    0

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS    40
`define STRAP_SETTLE_NS  1000
`define STRAP_SETTLE_CYC \
    ((`STRAP_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* File: gpio_datapath_pkg.sv */
// types shared by the control bank and its helpers
package gpio_datapath_pkg;

    // io pin mode field encodings
    typedef enum logic [1:0] {
        MODE_FUNC_IN = 2'b00,
        MODE_HIZ     = 2'b10,
        MODE_DRIVE   = 2'b01,
        MODE_READ    = 2'b11
    } io_mode_e;

    // strap tracker states, one-hot
    typedef enum logic [1:0] {
        ST_LOCKED   = 2'b01,
        ST_SETTLING = 2'b10
    } strap_state_e;

endpackage : gpio_datapath_pkg

/* File: io_pin_ctrl.sv */
// one general io pin: mode decode, pin drive and readback
`timescale 1ns/100ps
module io_pin_ctrl
    import gpio_datapath_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       reset_n,
    input  wire logic       clkEn,
    input  wire logic [1:0] mode,
    input  wire logic       outValue,
    input  wire logic       pinIn,
    output logic            pinOut,
    output logic            pinOeN,
    output logic            funcIn,
    output logic            readValue
);
    logic next_funcIn;
    logic next_readValue;

    always_comb begin
        pinOut         = (mode == MODE_DRIVE) ? outValue : 1'b0;
        pinOeN         = (mode != MODE_DRIVE);
        next_funcIn    = (mode == MODE_FUNC_IN) ? pinIn : 1'b0;
        next_readValue = (mode == MODE_READ) ? pinIn : readValue;
    end

    // readback holds its last value outside read mode
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            funcIn    <= 1'b0;
            readValue <= 1'b0;
        end else if (clkEn) begin
            funcIn    <= next_funcIn;
            readValue <= next_readValue;
        end
    end
endmodule : io_pin_ctrl

/* File: strap_level_tracker.sv */
// latches a decoded strap level once it has held still long enough
`timescale 1ns/100ps
module strap_level_tracker
    import gpio_datapath_pkg::*;
#(
    parameter int SETTLE = 25
) (
    input  wire logic       ref_clk,
    input  wire logic       reset_n,
    input  wire logic       clkEn,
    input  wire logic [2:0] levelIn,
    output logic            done,
    output logic [2:0]      decode
);
    strap_state_e state, next_state;
    logic [7:0]   count, next_count;
    logic [2:0]   cand, next_cand, next_decode;
    logic         next_done;

    // a change drops done until the new level has settled
    always_comb begin
        next_state  = state;
        next_count  = count;
        next_cand   = cand;
        next_decode = decode;
        next_done   = done;
        case (state)
            ST_LOCKED: begin
                if (levelIn != decode) begin
                    next_state = ST_SETTLING;
                    next_cand  = levelIn;
                    next_count = 8'h00;
                    next_done  = 1'b0;
                end
            end
            ST_SETTLING: begin
                if (levelIn != cand) begin
                    next_cand  = levelIn;
                    next_count = 8'h00;
                end else if (count == 8'(SETTLE - 1)) begin
                    next_state  = ST_LOCKED;
                    next_decode = cand;
                    next_done   = 1'b1;
                end else begin
                    next_count = count + 8'h01;
                end
            end
            default: next_state = ST_LOCKED;
        endcase
    end

    // done starts set to match the status reset value
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state  <= ST_LOCKED;
            count  <= 8'h00;
            cand   <= 3'h0;
            decode <= 3'h0;
            done   <= 1'b1;
        end else if (clkEn) begin
            state  <= next_state;
            count  <= next_count;
            cand   <= next_cand;
            decode <= next_decode;
            done   <= next_done;
        end
    end
endmodule : strap_level_tracker

/* File: gpio_datapath_strap_regs_assertions.sv */
// concurrent checks on the io config and path control register bank
`timescale 1ns/100ps
module gpio_datapath_strap_regs_assertions (
    input wire logic        ref_clk,
    input wire logic        reset_n,
    input wire logic        clkEn,
    input wire logic [7:0]  regAddr,
    input wire logic        regWrite,
    input wire logic [7:0]  regWrData,
    input wire logic        regRead,
    input wire logic [7:0]  regRdData,
    input wire logic        ioSevenPinOeN,
    input wire logic        ioEightPinOut,
    input wire logic        deIn,
    input wire logic        pixelValid,
    input wire logic [23:0] pixelOut,
    input wire logic        cipherDisable,
    input wire logic        packetAudioBlock,
    input wire logic        deActiveLow,
    input wire logic        videoEighteenBit,
    input wire logic        audioData,
    input wire logic        auxAudioData,
    input wire logic        auxAudioEnable,
    input wire logic        auxAudioInputPin,
    input wire logic        repeaterMode,
    input wire logic        inbandAuxDetect,
    input wire logic        audioInFrame
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    // ------------------------------------------------------------
    // register port steps
    // ------------------------------------------------------------
    sequence s_io_wr;
        clkEn && regWrite && regAddr == 8'h11;
    endsequence
    sequence s_path_wr;
        clkEn && regWrite && regAddr == 8'h12;
    endsequence
    // a stray address must read as zero
    sequence s_odd_rd;
        clkEn && regRead && (regAddr < 8'h11 || regAddr > 8'h13);
    endsequence

    property p_io7_mode;
        s_io_wr |=> ioSevenPinOeN == (($past(regWrData) & 8'h03) != 8'h01);
    endproperty
    a_io7_mode: assert property (p_io7_mode)
        else $error("io seven enable does not follow mode");
    property p_io8_out;
        s_io_wr |=> ioEightPinOut == (($past(regWrData) & 8'hb0) == 8'h90);
    endproperty
    a_io8_out: assert property (p_io8_out)
        else $error("io eight drive value wrong");
    property p_pix_valid;
        clkEn |=> pixelValid == ($past(cipherDisable)
                                 | ($past(deIn) ^ $past(deActiveLow)));
    endproperty
    a_pix_valid: assert property (p_pix_valid)
        else $error("pixel qualifier wrong");
    property p_pass_block;
        clkEn && cipherDisable |-> packetAudioBlock
                                   ##1 (!audioData && !auxAudioData);
    endproperty
    a_pass_block: assert property (p_pass_block)
        else $error("audio not blocked in pass-through");
    property p_vid18;
        clkEn && videoEighteenBit |=> (pixelOut & 24'h030303) == 24'h0;
    endproperty
    a_vid18: assert property (p_vid18)
        else $error("low colour bits kept in narrow mode");
    property p_frame;
        s_path_wr |=> audioInFrame == (($past(regWrData) & 8'h02) != 8'h0);
    endproperty
    a_frame: assert property (p_frame)
        else $error("audio transport select wrong");
    property p_aux_data;
        clkEn && auxAudioEnable && !cipherDisable
            |=> auxAudioData == $past(auxAudioInputPin);
    endproperty
    a_aux_data: assert property (p_aux_data)
        else $error("second audio channel data wrong");
    property p_aux_en;
        s_path_wr |=> auxAudioEnable ==
            ((repeaterMode && ($past(regWrData) & 8'h08) == 8'h0)
             ? inbandAuxDetect : (($past(regWrData) & 8'h01) != 8'h0));
    endproperty
    a_aux_en: assert property (p_aux_en)
        else $error("second audio channel enable wrong");
    property p_odd_rd;
        s_odd_rd |=> regRdData == 8'h00;
    endproperty
    a_odd_rd: assert property (p_odd_rd)
        else $error("unmapped read not zero");
endmodule : gpio_datapath_strap_regs_assertions

bind gpio_datapath_strap_regs gpio_datapath_strap_regs_assertions chk_i (
    .ref_clk, .reset_n, .clkEn, .regAddr, .regWrite, .regWrData, .regRead,
    .regRdData, .ioSevenPinOeN, .ioEightPinOut, .deIn, .pixelValid,
    .pixelOut, .cipherDisable, .packetAudioBlock, .deActiveLow,
    .videoEighteenBit, .audioData, .auxAudioData, .auxAudioEnable,
    .auxAudioInputPin, .repeaterMode, .inbandAuxDetect, .audioInFrame
);

/* File: testbench.sv */
// self-checking bench for the io config, path control and strap bank
`timescale 1ns/100ps
module testbench;
    logic        ref_clk = 0, reset_n = 0, clkEn = 1;
    logic [7:0]  regAddr = 0, regWrData = 0, regRdData, d;
    logic        regWrite = 0, regRead = 0, regRdValid;
    logic        ioSevenPinIn = 0, ioEightPinIn = 0;
    logic        ioSevenPinOut, ioSevenPinOeN, ioSevenFuncIn, ioSevenReadValue;
    logic        ioEightPinOut, ioEightPinOeN, ioEightFuncIn, ioEightReadValue;
    logic [2:0]  strapZeroLevel = 0, strapOneLevel = 0;
    logic        deIn = 0, pixelValid;
    logic [23:0] pixelIn = 24'hffffff, pixelOut;
    logic        repeaterMode = 0, inbandAuxDetect = 0;
    logic        audioFromVideo = 1, audioFromPins = 0, auxAudioInputPin = 1;
    logic        audioData, auxAudioData, auxAudioEnable, audioInFrame;
    logic        packetAudioBlock, cipherDisable, videoEighteenBit;
    logic        deActiveLow, pass, ev, ae, au;
    int          bad_count = 0, checked = 0;
    logic [7:0]  pv [11] = '{8'h00, 8'h40, 8'h20, 8'h04, 8'h02, 8'h10,
                             8'h01, 8'h09, 8'h08, 8'h41, 8'hff};

    gpio_datapath_strap_regs dut (.*);

    always #20 ref_clk = ~ref_clk;

    // ------------------------------------------------------------
    // access and compare tasks
    // ------------------------------------------------------------
    task conclude;
        $display("comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : conclude

    task chk(input logic [23:0] s, input logic [23:0] e, input string m);
        checked++;
        if (s !== e) begin
            bad_count++;
            $display("[FAIL] %0t %s seen %h expected %h", $time, m, s, e);
        end
    endtask : chk

    // strobes rise at a falling edge, drop after one rising edge, rest a cycle
    task wr(input logic [7:0] a, input logic [7:0] v);
        regAddr = a;
        regWrData = v;
        regWrite = 1;
        @(negedge ref_clk);
        regWrite = 0;
        @(negedge ref_clk);
    endtask : wr

    // bounded wait for the read answer; a lost answer ends the run
    task rd(input logic [7:0] a, output logic [7:0] v);
        int i;
        regAddr = a;
        regRead = 1;
        @(negedge ref_clk);
        regRead = 0;
        for (i = 0; i < 4 && regRdValid !== 1'b1; i++) @(negedge ref_clk);
        if (i == 4) begin
            bad_count++;
            conclude();
        end
        v = regRdData;
        @(negedge ref_clk);
    endtask : rd

    task rdc(input logic [7:0] a, input logic [7:0] e);
        rd(a, d);
        chk(d, e, "register read");
    endtask : rdc

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (5) @(negedge ref_clk);
        reset_n = 1;
        rdc(8'h11, 8'h00);
        rdc(8'h12, 8'h00);
        rdc(8'h13, 8'h88);
        wr(8'h11, 8'hff);
        rdc(8'h11, 8'hbb);
        wr(8'h13, 8'h00);
        rdc(8'h13, 8'h88);
        rdc(8'h10, 8'h00);
        rdc(8'h20, 8'h00);
        // every mode with both drive values; pins set opposite ways
        for (int m = 0; m < 4; m++) for (int v = 0; v < 2; v++) begin
            ioSevenPinIn = !v[0];
            ioEightPinIn = v[0];
            wr(8'h11, {v[0], 1'b0, m[1:0], v[0], 1'b0, m[1:0]});
            @(negedge ref_clk);
            chk(ioSevenPinOeN, m != 1, "seven enable");
            chk(ioEightPinOeN, m != 1, "eight enable");
            chk(ioSevenPinOut, m == 1 && v[0], "seven drive");
            chk(ioEightPinOut, m == 1 && v[0], "eight drive");
            chk(ioSevenFuncIn, m == 0 && !v[0], "seven func");
            chk(ioEightFuncIn, m == 0 && v[0], "eight func");
            if (m == 3) begin
                chk(ioSevenReadValue, !v[0], "seven read");
                chk(ioEightReadValue, v[0], "eight read");
            end
        end
        // a write while the clock enable is low must not land
        clkEn = 0;
        wr(8'h11, 8'h00);
        clkEn = 1;
        rdc(8'h11, 8'hbb);
        // path control settings against repeater and data-enable levels
        foreach (pv[i]) for (int r = 0; r < 2; r++)
            for (int e = 0; e < 2; e++) begin
            wr(8'h12, pv[i]);
            repeaterMode = r[0];
            deIn = e[0];
            inbandAuxDetect = !pv[i][0];
            audioFromPins = e[0];
            audioFromVideo = !e[0];
            auxAudioInputPin = e[0];
            @(negedge ref_clk);
            pass = pv[i][6];
            ev = pass | (e[0] ^ pv[i][5]);
            ae = (r[0] && !pv[i][3]) ? !pv[i][0] : pv[i][0];
            au = !pass && ((r[0] && pv[i][4]) ? e[0] : !e[0]);
            chk(cipherDisable, pass, "cipher off");
            chk(packetAudioBlock, pass, "packet block");
            chk(deActiveLow, pv[i][5], "de polarity");
            chk(pixelValid, ev, "pixel valid");
            chk(pixelOut, !ev ? 24'h0 : pv[i][2] ? 24'hfcfcfc
                          : 24'hffffff, "pixel data");
            chk(videoEighteenBit, pv[i][2], "colour depth");
            chk(audioInFrame, pv[i][1], "transport");
            chk(audioData, au, "audio");
            chk(auxAudioEnable, ae, "aux enable");
            chk(auxAudioData, ae && !pass && e[0], "aux data");
            rdc(8'h12, pv[i] & 8'h7f);
        end
        // strap change clears both done bits, then relatches
        strapZeroLevel = 3'd5;
        strapOneLevel = 3'd3;
        @(negedge ref_clk);
        @(negedge ref_clk);
        rd(8'h13, d);
        chk(d & 8'h88, 8'h00, "done bits cleared");
        repeat (30) @(negedge ref_clk);
        rdc(8'h13, 8'hbd);
        // second reset in mid-run
        deIn = 0;
        reset_n = 0;
        @(negedge ref_clk);
        reset_n = 1;
        rdc(8'h11, 8'h00);
        rdc(8'h12, 8'h00);
        conclude();
    end
endmodule : testbench
